// ===== design/blsc_pkg.sv
/*
 * Package for the black-level and sync output control block: register
 * word indices, reset values, field positions and carrier structs.
 * Assumes a 32-bit APB bus with one register per aligned word.
 */
package blsc_pkg;

   // Printed offsets are not all multiples of four: they are word indices
   localparam logic [7:0] IDX_RED_TARGET = 8'h1D;
   localparam logic [7:0] IDX_GREEN_TARGET = 8'h1E;
   localparam logic [7:0] IDX_BLUE_TARGET = 8'h1F;
   localparam logic [7:0] IDX_CLAMP = 8'h23;
   localparam logic [7:0] IDX_SYNC_CTRL = 8'h25;
   localparam logic [7:0] IDX_REF_MULT = 8'h2B;
   localparam logic [7:0] IDX_VIDEO_CFG = 8'h05;
   localparam logic [7:0] IDX_STATUS = 8'h3F;

   localparam logic [7:0] RST_TARGET = 8'h00;
   localparam logic [7:0] RST_CLAMP = 8'h18;
   localparam logic [7:0] RST_SYNC_CTRL = 8'h00;
   localparam logic [7:0] RST_REF_MULT = 8'h14;
   localparam logic [7:0] RST_VIDEO_CFG = 8'h00;

   // Writable bit masks; reserved bits keep their reset value
   localparam logic [7:0] MASK_CLAMP = 8'h70;
   localparam logic [7:0] MASK_SYNC_CTRL = 8'h97;

   localparam int CLAMP_LSB = 4;
   localparam int SYNC_TRI_BIT = 0;
   localparam int SYNC_HOLD_POL_BIT = 1;
   localparam int SYNC_LOCK_EDGE_BIT = 2;
   localparam int SYNC_RAW_FRAME_BIT = 4;
   localparam int SYNC_HOLD_ON_FRAME_BIT = 7;
   localparam int CFG_COMPONENT_BIT = 2;
   localparam int CFG_SERVO_EN_BIT = 0;

   localparam logic [7:0] BASE_RGB = 8'h00;
   localparam logic [7:0] BASE_COMPONENT = 8'h80;
   localparam logic [7:0] POS_LIMIT = 8'h7F;
   localparam logic [7:0] LINE_WIDTH_RST = 8'h10;

   typedef struct packed {
      logic [7:0] addr_idx;
      logic write;
      logic [7:0] wdata;
   } blsc_req_t;

   typedef struct packed {
      logic line_sync;
      logic frame_sync;
      logic pixel_line;
      logic pixel_frame;
   } blsc_sync_t;

endpackage

// ===== design/blsc_target_calc.sv
/*
 * One colour channel's black-level goal code: base plus signed target,
 * clamped to the range the mode allows. Purely combinational.
 * Assumes the caller supplies the servo enable and the mode bits.
 */
`timescale 1ns/10ps
module blsc_target_calc
   import blsc_pkg::*;
(
   input wire logic [7:0] target,
   input wire logic component_mode,
   input wire logic mid_capable,
   input wire logic servo_en,
   input wire logic [7:0] raw_code,
   output logic [7:0] goal_code,
   output logic goal_valid
);

   logic use_mid;
   logic [7:0] limited;

   // Unipolar channels accept only 0..+7F, negatives pin to zero
   always_comb begin
      use_mid = component_mode & mid_capable;
      if (use_mid) begin
         limited = target;
      end else if (target[7]) begin
         limited = BASE_RGB;
      end else begin
         limited = target & POS_LIMIT;
      end
      // Base plus signed target; wraps only in the mid-scale case by design
      if (servo_en) begin
         goal_code = (use_mid ? BASE_COMPONENT : BASE_RGB) + limited;
      end else begin
         goal_code = raw_code;
      end
      goal_valid = servo_en;
   end

endmodule

// ===== design/blsc_regs.sv
/*
 * Register bank and sync output stage of the digitizer control block:
 * APB slave, black-level goals per channel, clamp strength, sync
 * three-state, hold-window polarity, lock edge and frame-sync routing.
 * Assumes syncs arrive synchronous to ref_clk, one clock per pixel.
 */
// The APB register port was chosen for this implementation.
`timescale 1ns/10ps
// Notes on behaviour
// - Each channel has an 8-bit signed target register for the servo.
// - RGB mode: red goal is 0x00 plus target limited to 0..+7F.
// - Component mode: red goal is 0x80 plus target, -80..+7F.
// - Green goal is always 0x00 plus target limited to 0..+7F.
// - RGB mode: blue goal is 0x00 plus target limited to 0..+7F.
// - Component mode: blue goal is 0x80 plus target, -80..+7F.
// - Targets never disable the digital offset adder; both apply together.
// - Shared 3-bit clamp field: zero disconnects, 1..7 lower resistance.
// - Sync control bit 0 three-states all four sync outputs.
// - Sync control bit 1 picks hold-window polarity, 0 active high.
// - Bit 4: frame sync aligned to line sync, or raw integrator.
// - Bit 7 routes the hold window onto the pixel frame-sync pin.
// - Config register 0x05 bit 2 selects component-video processing.
module blsc_regs
   import blsc_pkg::*;
(
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [7:0] red_code,
   input wire logic [7:0] green_code,
   input wire logic [7:0] blue_code,
   input wire logic [7:0] offset_adjust,
   input wire logic line_sync_input,
   input wire logic composite_sync_input,
   input wire logic raw_frame_sync,
   input wire logic hold_window_in,
   input wire logic [7:0] line_width,
   output logic [23:0] goal_codes,
   output logic [23:0] adjusted_codes,
   output logic servo_active,
   output logic [2:0] clamp_strength,
   output logic clamp_connected,
   output logic [7:0] reference_multiplier,
   output logic hold_active,
   output logic line_sync_regen_out,
   output logic frame_sync_regen_out,
   output logic pixel_line_sync_out,
   output logic pixel_frame_sync_out,
   output logic [3:0] sync_oe
);

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_LEAD = 3'b010,
      ST_PULSE = 3'b100
   } blsc_line_st_t;

   logic [7:0] red_black_target, next_red_black_target;
   logic [7:0] green_black_target, next_green_black_target;
   logic [7:0] blue_black_target, next_blue_black_target;
   logic [7:0] clamp_strength_ctrl, next_clamp_strength_ctrl;
   logic [7:0] sync_output_ctrl, next_sync_output_ctrl;
   logic [7:0] ref_mult, next_ref_mult;
   logic [7:0] video_cfg, next_video_cfg;
   logic [31:0] next_prdata;
   blsc_req_t req;
   logic hit, wr_en;
   logic [7:0] rd_byte;

   blsc_line_st_t line_st, next_line_st;
   logic [7:0] line_cnt, next_line_cnt;
   logic [7:0] lead_cnt, next_lead_cnt;
   logic [7:0] period, next_period;
   logic [7:0] period_cnt, next_period_cnt;
   logic prev_lock, next_prev_lock;
   logic line_regen, next_line_regen;
   logic frame_aligned, next_frame_aligned;
   logic line_regen_d;
   blsc_sync_t sync_q, next_sync;
   logic component_mode, servo_en, lock_edge, lock_event, hold_level;
   logic [7:0] r_goal, g_goal, b_goal;
   logic [7:0] r_adj, g_adj, b_adj;

   // Index from word address; paddr[1:0] ignored as the word is aligned
   always_comb begin
      req.addr_idx = paddr[9:2];
      req.write = pwrite;
      req.wdata = pwdata[7:0];
      hit = (paddr[31:10] == 22'h000000);
      wr_en = psel & penable & pwrite & pstrb[0];
   end

   // Zero-wait slave; unmapped words answer with an error, read zero
   always_comb begin
      pready = psel & penable;
      pslverr = 1'b0;
      rd_byte = 8'h00;
      case (req.addr_idx)
         IDX_RED_TARGET: rd_byte = red_black_target;
         IDX_GREEN_TARGET: rd_byte = green_black_target;
         IDX_BLUE_TARGET: rd_byte = blue_black_target;
         IDX_CLAMP: rd_byte = clamp_strength_ctrl;
         IDX_SYNC_CTRL: rd_byte = sync_output_ctrl;
         IDX_REF_MULT: rd_byte = ref_mult;
         IDX_VIDEO_CFG: rd_byte = video_cfg;
         IDX_STATUS: rd_byte = {4'h0, hold_level, line_regen,
            clamp_connected, servo_en};
         default: pslverr = psel & penable;
      endcase
      if (!hit) begin
         pslverr = psel & penable;
         rd_byte = 8'h00;
      end
   end

   // Register writes; reserved bits hold their reset pattern
   always_comb begin
      next_red_black_target = red_black_target;
      next_green_black_target = green_black_target;
      next_blue_black_target = blue_black_target;
      next_clamp_strength_ctrl = clamp_strength_ctrl;
      next_sync_output_ctrl = sync_output_ctrl;
      next_ref_mult = ref_mult;
      next_video_cfg = video_cfg;
      next_prdata = prdata;
      // Loaded in the setup phase so the word stands at the access edge
      if (psel & !penable & !pwrite) begin
         next_prdata = {24'h000000, rd_byte};
      end
      if (wr_en & hit) begin
         case (req.addr_idx)
            IDX_RED_TARGET: next_red_black_target = req.wdata;
            IDX_GREEN_TARGET: next_green_black_target = req.wdata;
            IDX_BLUE_TARGET: next_blue_black_target = req.wdata;
            IDX_CLAMP: next_clamp_strength_ctrl = (req.wdata & MASK_CLAMP)
               | (RST_CLAMP & ~MASK_CLAMP);
            IDX_SYNC_CTRL: next_sync_output_ctrl = req.wdata & MASK_SYNC_CTRL;
            IDX_REF_MULT: next_ref_mult = req.wdata;
            IDX_VIDEO_CFG: next_video_cfg = req.wdata;
            default: next_ref_mult = ref_mult;
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         red_black_target <= RST_TARGET;
         green_black_target <= RST_TARGET;
         blue_black_target <= RST_TARGET;
         clamp_strength_ctrl <= RST_CLAMP;
         sync_output_ctrl <= RST_SYNC_CTRL;
         ref_mult <= RST_REF_MULT;
         video_cfg <= RST_VIDEO_CFG;
         prdata <= 32'h00000000;
      end else begin
         red_black_target <= next_red_black_target;
         green_black_target <= next_green_black_target;
         blue_black_target <= next_blue_black_target;
         clamp_strength_ctrl <= next_clamp_strength_ctrl;
         sync_output_ctrl <= next_sync_output_ctrl;
         ref_mult <= next_ref_mult;
         video_cfg <= next_video_cfg;
         prdata <= next_prdata;
      end
   end

   // Mode and field decode
   always_comb begin
      component_mode = video_cfg[CFG_COMPONENT_BIT];
      servo_en = video_cfg[CFG_SERVO_EN_BIT];
      lock_edge = sync_output_ctrl[SYNC_LOCK_EDGE_BIT];
      clamp_strength = clamp_strength_ctrl[CLAMP_LSB +: 3];
      clamp_connected = (clamp_strength != 3'h0);
      reference_multiplier = ref_mult;
      servo_active = servo_en;
      hold_level = hold_window_in ^ sync_output_ctrl[SYNC_HOLD_POL_BIT];
      hold_active = hold_level;
   end

   // One goal calculator per channel; only red and blue take mid-scale
   blsc_target_calc u_red (
      .target(red_black_target),
      .component_mode(component_mode),
      .mid_capable(1'b1),
      .servo_en(servo_en),
      .raw_code(red_code),
      .goal_code(r_goal),
      .goal_valid()
   );
   blsc_target_calc u_green (
      .target(green_black_target),
      .component_mode(component_mode),
      .mid_capable(1'b0),
      .servo_en(servo_en),
      .raw_code(green_code),
      .goal_code(g_goal),
      .goal_valid()
   );
   blsc_target_calc u_blue (
      .target(blue_black_target),
      .component_mode(component_mode),
      .mid_capable(1'b1),
      .servo_en(servo_en),
      .raw_code(blue_code),
      .goal_code(b_goal),
      .goal_valid()
   );

   // Offset adder always applies, independent of the servo goals
   always_comb begin
      r_adj = red_code + offset_adjust;
      g_adj = green_code + offset_adjust;
      b_adj = blue_code + offset_adjust;
   end

   // Lock edge: rising edge of line_sync_input; composite_sync_input is not used
   always_comb begin
      lock_event = line_sync_input & !prev_lock;
      next_prev_lock = line_sync_input;
   end

   // Line regeneration; trailing-edge lock needs the prior line period
   // to start the pulse early, so the first line after reset is skipped
   always_comb begin
      next_line_st = line_st;
      next_line_cnt = line_cnt;
      next_lead_cnt = lead_cnt;
      next_line_regen = line_regen;
      next_period = period;
      next_period_cnt = (period_cnt == 8'hFF) ? period_cnt
         : period_cnt + 8'h01;
      if (lock_event) begin
         next_period = period_cnt;
         next_period_cnt = 8'h00;
      end
      case (line_st)
         ST_IDLE: begin
            next_line_regen = 1'b0;
            if (lock_edge && lock_event) begin
               next_line_regen = 1'b1;
               next_line_cnt = line_width;
               next_line_st = ST_PULSE;
            end else if (!lock_edge && period > line_width
               && period_cnt == period - line_width) begin
               next_line_regen = 1'b1;
               next_line_cnt = line_width;
               next_line_st = ST_PULSE;
            end
         end
         ST_LEAD: begin
            next_line_st = ST_IDLE;
         end
         ST_PULSE: begin
            next_line_cnt = line_cnt - 8'h01;
            if (line_cnt <= 8'h01) begin
               next_line_regen = 1'b0;
               next_line_st = ST_IDLE;
            end
         end
         default: begin
            next_line_st = ST_IDLE;
            next_line_regen = 1'b0;
         end
      endcase
      next_lead_cnt = lead_cnt;
   end

   // Frame sync realigned to the regenerated line sync leading edge
   always_comb begin
      next_frame_aligned = frame_aligned;
      if (line_regen & !line_regen_d) begin
         next_frame_aligned = raw_frame_sync;
      end
      next_sync.line_sync = line_regen;
      next_sync.frame_sync = sync_output_ctrl[SYNC_RAW_FRAME_BIT]
         ? raw_frame_sync : frame_aligned;
      next_sync.pixel_line = line_regen;
      next_sync.pixel_frame = sync_output_ctrl[SYNC_HOLD_ON_FRAME_BIT]
         ? hold_level : next_sync.frame_sync;
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         line_st <= ST_IDLE;
         line_cnt <= 8'h00;
         lead_cnt <= 8'h00;
         period <= 8'h00;
         period_cnt <= 8'h00;
         prev_lock <= 1'b0;
         line_regen <= 1'b0;
         line_regen_d <= 1'b0;
         frame_aligned <= 1'b0;
         sync_q <= '0;
         goal_codes <= 24'h000000;
         adjusted_codes <= 24'h000000;
      end else begin
         line_st <= next_line_st;
         line_cnt <= next_line_cnt;
         lead_cnt <= next_lead_cnt;
         period <= next_period;
         period_cnt <= next_period_cnt;
         prev_lock <= next_prev_lock;
         line_regen <= next_line_regen;
         line_regen_d <= line_regen;
         frame_aligned <= next_frame_aligned;
         sync_q <= next_sync;
         goal_codes <= {r_goal, g_goal, b_goal};
         adjusted_codes <= {r_adj, g_adj, b_adj};
      end
   end

   // Pins: values registered; enables drop together when three-stated
   always_comb begin
      line_sync_regen_out = sync_q.line_sync;
      frame_sync_regen_out = sync_q.frame_sync;
      pixel_line_sync_out = sync_q.pixel_line;
      pixel_frame_sync_out = sync_q.pixel_frame;
      sync_oe = {4{~sync_output_ctrl[SYNC_TRI_BIT]}};
   end

endmodule

// ===== tb/blsc_video_sink.sv
/* Downstream video sink model: watches the pixel line and pixel frame sync pins.
   Assumes pins are sampled on ref_clk, one clock per pixel. */
`timescale 1ns/10ps
module blsc_video_sink
   import blsc_pkg::*;
(
   input wire logic ref_clk,
   input wire blsc_sync_t syncs,
   input wire logic [3:0] sync_oe,
   output logic [7:0] width_seen,
   output logic frame_seen
);
   logic [7:0] run = 8'h00;
   logic line_lv = 1'b0;
   initial width_seen = 8'h00;
   initial frame_seen = 1'b0;
   // No pull on the pins: an undriven pin shows the inverse of last level
   always @(posedge ref_clk) begin
      line_lv = (&sync_oe) ? syncs.pixel_line : ~line_lv;
      frame_seen <= (&sync_oe) ? syncs.pixel_frame : ~frame_seen;
      if (line_lv)
         run <= run + 8'h01;
      else if (run != 8'h00) begin
         width_seen <= run;
         run <= 8'h00;
      end
   end
endmodule

// ===== tb/blsc_regs_asserts.sv
/* Checker for blsc_regs: outputs against a shadow of APB writes.
   Assumes it is bound to blsc_regs; one clock, synchronous reset. */
`timescale 1ns/10ps
module blsc_regs_chk
   import blsc_pkg::*;
(
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic [7:0] red_code,
   input wire logic [7:0] green_code,
   input wire logic [7:0] blue_code,
   input wire logic [7:0] offset_adjust,
   input wire logic line_sync_input,
   input wire logic raw_frame_sync,
   input wire logic hold_window_in,
   input wire logic [23:0] goal_codes,
   input wire logic [23:0] adjusted_codes,
   input wire logic servo_active,
   input wire logic [2:0] clamp_strength,
   input wire logic clamp_connected,
   input wire logic [7:0] reference_multiplier,
   input wire logic hold_active,
   input wire logic line_sync_regen_out,
   input wire logic frame_sync_regen_out,
   input wire logic pixel_line_sync_out,
   input wire logic pixel_frame_sync_out,
   input wire logic [3:0] sync_oe
);
   logic [39:0] sh;
   logic [39:0] next_sh;
   logic wr;
   logic [23:0] exp_goal;
   function automatic logic [7:0] gl(input logic [7:0] t, input logic m);
      return m ? t + BASE_COMPONENT : (t[7] ? BASE_RGB : t);
   endfunction
   // Shadow: targets, video config, sync control (strobe low ignored)
   assign wr = psel && penable && pwrite && pstrb[0];
   always_comb begin
      next_sh = sh;
      if (wr && paddr == 32'h74) next_sh[39:32] = pwdata[7:0];
      if (wr && paddr == 32'h78) next_sh[31:24] = pwdata[7:0];
      if (wr && paddr == 32'h7C) next_sh[23:16] = pwdata[7:0];
      if (wr && paddr == 32'h14) next_sh[15:8] = pwdata[7:0];
      if (wr && paddr == 32'h94) next_sh[7:0] = pwdata[7:0] & MASK_SYNC_CTRL;
      if (!resetn) next_sh = 40'h0;
   end
   always_ff @(posedge ref_clk) begin
      sh <= next_sh;
   end
   // Green never takes the mid-scale base
   assign exp_goal = {gl(sh[39:32], sh[10]), gl(sh[31:24], 1'b0),
      gl(sh[23:16], sh[10])};
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   sequence s_wr(logic [31:0] a);
      wr && paddr == a;
   endsequence
   property p_goal; servo_active |=> goal_codes == $past(exp_goal); endproperty
   a_goal: assert property (p_goal) else $error("goal off");
   property p_bypass;
      resetn && !servo_active
         |=> goal_codes == $past({red_code, green_code, blue_code});
   endproperty
   a_bypass: assert property (p_bypass) else $error("bypass off");
   property p_adj;
      resetn |=> adjusted_codes == $past({red_code + offset_adjust,
         green_code + offset_adjust, blue_code + offset_adjust});
   endproperty
   a_adj: assert property (p_adj) else $error("offset sum off");
   property p_servo; servo_active == sh[8]; endproperty
   a_servo: assert property (p_servo) else $error("servo state off");
   property p_clamp;
      s_wr(32'h8C) |=> clamp_connected == ($past(pwdata[6:4]) != 3'h0);
   endproperty
   a_clamp: assert property (p_clamp) else $error("clamp link off");
   property p_clamp_wr;
      s_wr(32'h8C) |=> clamp_strength == $past(pwdata[6:4]);
   endproperty
   a_clamp_wr: assert property (p_clamp_wr) else $error("clamp off");
   property p_mult;
      s_wr(32'hAC) |=> reference_multiplier == $past(pwdata[7:0]);
   endproperty
   a_mult: assert property (p_mult) else $error("multiplier off");
   property p_tri; sync_oe == (sh[0] ? 4'h0 : 4'hF); endproperty
   a_tri: assert property (p_tri) else $error("enables off");
   property p_pol; hold_active == (hold_window_in ^ sh[1]); endproperty
   a_pol: assert property (p_pol) else $error("hold polarity off");
   property p_lead;
      sh[2] && $rose(line_sync_input) |-> ##[1:3] $rose(pixel_line_sync_out);
   endproperty
   a_lead: assert property (p_lead) else $error("lead edge late");
   property p_trail;
      !sh[2] && line_sync_regen_out && $rose(line_sync_input)
         |-> ##[0:2] !line_sync_regen_out;
   endproperty
   a_trail: assert property (p_trail) else $error("trail edge late");
   property p_raw;
      (sh[4] && raw_frame_sync)[*3] |-> frame_sync_regen_out;
   endproperty
   a_raw: assert property (p_raw) else $error("raw frame lost");
   property p_hold; (sh[7] && hold_active)[*4] |-> pixel_frame_sync_out;
   endproperty
   a_hold: assert property (p_hold) else $error("hold not on pin");
endmodule
bind blsc_regs blsc_regs_chk i_chk(.ref_clk(ref_clk), .resetn(resetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .pstrb(pstrb), .red_code(red_code),
   .green_code(green_code), .blue_code(blue_code),
   .offset_adjust(offset_adjust), .line_sync_input(line_sync_input),
   .raw_frame_sync(raw_frame_sync), .hold_window_in(hold_window_in),
   .goal_codes(goal_codes), .adjusted_codes(adjusted_codes),
   .servo_active(servo_active), .clamp_strength(clamp_strength),
   .clamp_connected(clamp_connected),
   .reference_multiplier(reference_multiplier), .hold_active(hold_active),
   .line_sync_regen_out(line_sync_regen_out),
   .frame_sync_regen_out(frame_sync_regen_out),
   .pixel_line_sync_out(pixel_line_sync_out),
   .pixel_frame_sync_out(pixel_frame_sync_out), .sync_oe(sync_oe));

// ===== tb/black_level_sync_output_ctrl_test.sv
/* Self-checking bench for blsc_regs: register table over APB, goals,
   sync controls. Assumes blsc_pkg, the video sink and the checker. */
`timescale 1ns/10ps
module black_level_sync_output_ctrl_test
   import blsc_pkg::*;
;
   logic ref_clk = 1'b0, resetn = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata;
   logic [3:0] pstrb = 4'hF, sync_oe;
   logic [7:0] red_code = 8'h00, green_code = 8'h00, blue_code = 8'h00;
   logic [7:0] offset_adjust = 8'h00, line_width = 8'h03;
   logic line_sync_input = 1'b0, raw_frame_sync = 1'b0;
   logic hold_window_in = 1'b0, pready, pslverr, erv, frame_seen;
   logic [23:0] goal_codes, adjusted_codes;
   logic servo_active, clamp_connected, hold_active;
   logic [2:0] clamp_strength;
   logic [7:0] reference_multiplier, width_seen, rdv;
   logic [4:0] lcnt = 5'h00;
   wire blsc_sync_t syncs;
   int fails = 0, checks_done = 0, i;
   logic [7:0] ra [7] = '{IDX_RED_TARGET, IDX_GREEN_TARGET, IDX_BLUE_TARGET,
      IDX_CLAMP, IDX_SYNC_CTRL, IDX_REF_MULT, IDX_VIDEO_CFG};
   logic [7:0] rw [7] = '{8'hA5, 8'h81, 8'h7F, 8'hFF, 8'hFF, 8'h20, 8'h05};
   logic [7:0] rx [7] = '{8'hA5, 8'h81, 8'h7F, 8'h78, 8'h97, 8'h20, 8'h05};
   logic [7:0] rv [7] = '{RST_TARGET, RST_TARGET, RST_TARGET, RST_CLAMP,
      RST_SYNC_CTRL, RST_REF_MULT, RST_VIDEO_CFG};
   blsc_regs i_blsc_regs(.ref_clk(ref_clk), .resetn(resetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .red_code(red_code), .green_code(green_code), .blue_code(blue_code),
      .offset_adjust(offset_adjust), .line_sync_input(line_sync_input),
      .composite_sync_input(1'b0), .raw_frame_sync(raw_frame_sync),
      .hold_window_in(hold_window_in), .line_width(line_width),
      .goal_codes(goal_codes), .adjusted_codes(adjusted_codes),
      .servo_active(servo_active), .clamp_strength(clamp_strength),
      .clamp_connected(clamp_connected), .hold_active(hold_active),
      .reference_multiplier(reference_multiplier),
      .line_sync_regen_out(syncs.line_sync),
      .frame_sync_regen_out(syncs.frame_sync),
      .pixel_line_sync_out(syncs.pixel_line),
      .pixel_frame_sync_out(syncs.pixel_frame), .sync_oe(sync_oe));
   blsc_video_sink i_blsc_video_sink(.ref_clk(ref_clk), .syncs(syncs),
      .sync_oe(sync_oe), .width_seen(width_seen), .frame_seen(frame_seen));
   always #5 ref_clk = ~ref_clk;
   // Incoming line sync: 2-clock pulse every 20 clocks
   always @(posedge ref_clk) begin
      lcnt <= (lcnt == 5'h13) ? 5'h00 : lcnt + 5'h01;
      line_sync_input <= (lcnt < 5'h02);
   end
   task chk(input string what, input logic [31:0] got, input logic [31:0] e);
      checks_done++;
      if (got !== e) begin
         fails++;
         $display("wrong value %s expected %h seen %h", what, e, got);
      end
   endtask
   // Word index becomes byte address; read data taken at the access edge
   task apb(input logic [7:0] a, input logic w, input logic [7:0] d);
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {22'h0, a, 2'h0};
      pwdata <= {24'h0, d};
      @(posedge ref_clk);
      penable <= 1'b1;
      // Waits as long as the slave needs; only the watchdog ends it
      do begin
         @(posedge ref_clk);
      end while (pready !== 1'b1);
      erv = pslverr;
      rdv = prdata[7:0];
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge ref_clk);
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d);
      apb(a, 1'b1, d);
   endtask
   task wt(input int n);
      repeat (n) @(posedge ref_clk);
   endtask
   task end_of_test;
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // Bounded run: the tests take well under a thousand clocks
   initial begin
      wt(5000);
      fails++;
      end_of_test();
   end
   initial begin
      wt(20);
      resetn <= 1'b1;
      for (i = 0; i < 7; i++) begin
         wr(ra[i], rw[i]);
         apb(ra[i], 1'b0, 8'h00);
         chk("register", rdv, rx[i]);
      end
      apb(8'h40, 1'b1, 8'h5A);
      chk("unmapped error", erv, 1'b1);
      // Strobe low: write must be dropped
      pstrb <= 4'h0;
      wr(IDX_RED_TARGET, 8'h33);
      pstrb <= 4'hF;
      apb(IDX_RED_TARGET, 1'b0, 8'h00);
      chk("strobe", rdv, 8'hA5);
      red_code <= 8'h55;
      green_code <= 8'h66;
      blue_code <= 8'h77;
      offset_adjust <= 8'hF0;
      wr(IDX_RED_TARGET, 8'h90);
      wr(IDX_GREEN_TARGET, 8'h10);
      wr(IDX_VIDEO_CFG, 8'h01);
      wt(3);
      chk("goal rgb", goal_codes, 24'h00107F);
      chk("offset sum", adjusted_codes, 24'h455667);
      wr(IDX_VIDEO_CFG, 8'h05);
      wt(3);
      chk("goal component", goal_codes, 24'h1010FF);
      wr(IDX_VIDEO_CFG, 8'h04);
      wt(3);
      chk("goal servo off", goal_codes, 24'h556677);
      wr(IDX_SYNC_CTRL, 8'h01);
      chk("pins off", sync_oe, 4'h0);
      hold_window_in <= 1'b1;
      wr(IDX_SYNC_CTRL, 8'h04);
      chk("pins on", sync_oe, 4'hF);
      chk("hold high", hold_active, 1'b1);
      wt(60);
      chk("line width", width_seen, line_width);
      wr(IDX_SYNC_CTRL, 8'h02);
      chk("hold low", hold_active, 1'b0);
      // Internal frame extraction: polarity back to 0, hold on frame pin
      wr(IDX_SYNC_CTRL, 8'h80);
      wt(4);
      chk("hold on pin", frame_seen, 1'b1);
      hold_window_in <= 1'b0;
      wt(4);
      chk("hold off pin", frame_seen, 1'b0);
      wr(IDX_SYNC_CTRL, 8'h10);
      raw_frame_sync <= 1'b1;
      wt(4);
      chk("raw frame", syncs.frame_sync, 1'b1);
      // Trailing-edge lock, frame realigned to the regenerated line sync
      wr(IDX_SYNC_CTRL, 8'h00);
      wt(40);
      chk("trail width", width_seen, line_width);
      chk("aligned frame", syncs.frame_sync, 1'b1);
      // Reset must undo a three-state setting
      wr(IDX_SYNC_CTRL, 8'h01);
      resetn <= 1'b0;
      wt(2);
      resetn <= 1'b1;
      chk("pins reset", sync_oe, 4'hF);
      for (i = 0; i < 7; i++) begin
         apb(ra[i], 1'b0, 8'h00);
         chk("reset value", rdv, rv[i]);
      end
      end_of_test();
   end
endmodule
